// >>> rtl/erc_defines.svh
// Constants for the energy register calculator: channel indices, divisors, reset values and timing figures
`ifndef ERC_DEFINES_SVH
`define ERC_DEFINES_SVH

`define ERC_CLK_HZ          50000000
`define ERC_HOLD_TIME_MS    5000
`define ERC_TEST_TIMEOUT_S  32400
`define ERC_NUM_ACC         6
`define ERC_REFCFG_MAX      8'h19
`define ERC_WH_DIV          10000000
`define ERC_TSUM_DIV        10000
`define ERC_OUTLET_REF_RST  16'h1388
`define ERC_TARIFF_OFF      8'h00
`define ERC_CH_HEAT         0
`define ERC_CH_COOL         1
`define ERC_CH_DISC         2
`define ERC_CH_ADD          3
`define ERC_CH_TIN          4
`define ERC_CH_TOUT         5

`endif

// >>> rtl/erc_pkg.sv
// Types shared by the energy register calculator
package erc_pkg;

    typedef struct packed {
        logic [7:0]         vol_inc;
        logic signed [15:0] inlet_temp;
        logic signed [15:0] outlet_temp;
        logic [15:0]        coef_inlet;
        logic [15:0]        coef_outlet;
    } erc_meas_t;

    typedef struct packed {
        logic inlet_fail;
        logic outlet_fail;
        logic flow_fail;
    } erc_fault_t;

    typedef enum logic [2:0] {
        ERC_SEL_OUTLET_REF = 3'h0,
        ERC_SEL_LIMIT_A    = 3'h1,
        ERC_SEL_LIMIT_B    = 3'h2,
        ERC_SEL_LIMIT_C    = 3'h3,
        ERC_SEL_TARIFF     = 3'h4
    } erc_cfg_sel_t;

    typedef struct packed {
        logic signed [15:0] outlet_reference_temp;
        logic [15:0]        tariff_limit_a;
        logic [15:0]        tariff_limit_b;
        logic [15:0]        tariff_limit_c;
        logic [7:0]         tariff_type_code;
    } erc_cfg_t;

    typedef enum logic [1:0] {
        ERC_MODE_NORMAL  = 2'h0,
        ERC_MODE_TEST    = 2'h1,
        ERC_MODE_RELEASE = 2'h3
    } erc_mode_t;

endpackage

// >>> rtl/erc_calc.sv
// Energy register calculator core with configuration presets and mode control
`timescale 1ns/1ns
`default_nettype none
`include "erc_defines.svh"

module erc_calc #(
    parameter int                ACC_W          = 64,
    parameter int                TMR_W          = 48,
    parameter logic [TMR_W-1:0]  HOLD_CYCLES    =
        TMR_W'(64'(`ERC_HOLD_TIME_MS) * 64'(`ERC_CLK_HZ / 1000)),
    parameter logic [TMR_W-1:0]  TIMEOUT_CYCLES =
        TMR_W'(64'(`ERC_TEST_TIMEOUT_S) * 64'(`ERC_CLK_HZ))
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   total_reset_i,
    input  wire logic                   vol_tick_i,
    input  wire erc_pkg::erc_meas_t     meas_i,
    input  wire erc_pkg::erc_fault_t    fault_i,
    input  wire logic                   flow_in_outlet_i,
    input  wire logic                   cfg_wr_i,
    input  wire erc_pkg::erc_cfg_sel_t  cfg_sel_i,
    input  wire logic [15:0]            cfg_data_i,
    input  wire logic                   transport_state_i,
    input  wire logic                   at_setup_end_item_i,
    input  wire logic                   key_primary_i,
    input  wire logic                   key_secondary_i,
    input  wire logic                   test_contact_i,
    output logic [ACC_W-1:0]            heat_energy_o,
    output logic [ACC_W-1:0]            cooling_energy_o,
    output logic [ACC_W-1:0]            discount_energy_o,
    output logic [ACC_W-1:0]            addition_energy_o,
    output logic [ACC_W-1:0]            inlet_temp_sum_o,
    output logic [ACC_W-1:0]            outlet_temp_sum_o,
    output logic [ACC_W-1:0]            hr_volume_o,
    output erc_pkg::erc_cfg_t           cfg_o,
    output logic                        tariff_active_o,
    output logic                        setup_locked_o,
    output logic                        lock_pending_o,
    output logic                        test_mode_o,
    output logic                        test_exit_o,
    output logic [7:0]                  reconfig_count_o,
    output logic                        cfg_refused_o
);

    // Channel count and width of a signed temperature difference
    localparam int NCH = `ERC_NUM_ACC;
    localparam int TW  = 17;

    // Positive part of a - b, zero otherwise
    // One extra bit keeps the difference of two extreme readings exact
    function automatic logic [TW-1:0] pos_diff(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
        logic signed [TW-1:0] d;
        d = {a[15], a} - {b[15], b};
        pos_diff = (d > 0) ? d : '0;
    endfunction

    // Differences, per-channel increments, enables and accumulator state
    logic [TW-1:0]    dt_heat;
    logic [TW-1:0]    dt_cool;
    logic [TW-1:0]    dt_disc;
    logic [TW-1:0]    dt_add;
    logic [15:0]      coef_sel;
    logic [TW-1:0]    tin_pos;
    logic [TW-1:0]    tout_pos;
    logic             energy_ok;
    logic [ACC_W-1:0] inc       [NCH];
    logic             ch_en     [NCH];
    logic [ACC_W-1:0] acc_q     [NCH];
    logic [ACC_W-1:0] rem_q     [NCH];
    logic [ACC_W-1:0] hr_vol_q;

    // Temperature differences and per-channel increments
    always_comb begin
        coef_sel  = flow_in_outlet_i ? meas_i.coef_outlet : meas_i.coef_inlet;
        dt_heat   = pos_diff(meas_i.inlet_temp, meas_i.outlet_temp);
        dt_cool   = pos_diff(meas_i.outlet_temp, meas_i.inlet_temp);
        // Discount and addition only count while heat is flowing
        dt_disc   = (dt_heat != '0) ?
                    pos_diff(cfg_o.outlet_reference_temp, meas_i.outlet_temp) : '0;
        dt_add    = (dt_heat != '0) ?
                    pos_diff(meas_i.outlet_temp, cfg_o.outlet_reference_temp) : '0;
        // Sums ignore readings below zero
        tin_pos   = pos_diff(meas_i.inlet_temp, 16'sh0000);
        tout_pos  = pos_diff(meas_i.outlet_temp, 16'sh0000);
        energy_ok = !fault_i.inlet_fail && !fault_i.outlet_fail && !fault_i.flow_fail;
        // Energy increments in units of 1e-7 Wh, sums in 1e-4 of the sum unit
        inc[`ERC_CH_HEAT] = ACC_W'(meas_i.vol_inc) * ACC_W'(dt_heat) * ACC_W'(coef_sel);
        inc[`ERC_CH_COOL] = ACC_W'(meas_i.vol_inc) * ACC_W'(dt_cool) * ACC_W'(coef_sel);
        inc[`ERC_CH_DISC] = ACC_W'(meas_i.vol_inc) * ACC_W'(dt_disc) * ACC_W'(coef_sel);
        inc[`ERC_CH_ADD]  = ACC_W'(meas_i.vol_inc) * ACC_W'(dt_add) * ACC_W'(coef_sel);
        inc[`ERC_CH_TIN]  = ACC_W'(meas_i.vol_inc) * ACC_W'(tin_pos);
        inc[`ERC_CH_TOUT] = ACC_W'(meas_i.vol_inc) * ACC_W'(tout_pos);
        // Any failed reading stops all four energy channels
        ch_en[`ERC_CH_HEAT] = energy_ok;
        ch_en[`ERC_CH_COOL] = energy_ok;
        ch_en[`ERC_CH_DISC] = energy_ok;
        ch_en[`ERC_CH_ADD]  = energy_ok;
        ch_en[`ERC_CH_TIN]  = !fault_i.inlet_fail && !fault_i.flow_fail;
        ch_en[`ERC_CH_TOUT] = !fault_i.outlet_fail && !fault_i.flow_fail;
    end

    // One accumulator per channel, whole units plus carried remainder
    // Carrying the remainder keeps small flows from being lost to truncation
    // Clock enable low holds every register; reset still acts
    for (genvar ch = 0; ch < NCH; ch++) begin : g_acc
        localparam logic [ACC_W-1:0] DIV = (ch < 4) ? ACC_W'(`ERC_WH_DIV) :
                                                      ACC_W'(`ERC_TSUM_DIV);
        logic [ACC_W-1:0] sum;

        assign sum = rem_q[ch] + inc[ch];

        always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
                acc_q[ch] <= '0;
                rem_q[ch] <= '0;
            end else if (clk_en_i) begin
                if (total_reset_i) begin
                    acc_q[ch] <= '0;
                    rem_q[ch] <= '0;
                end else if (vol_tick_i && ch_en[ch]) begin
                    acc_q[ch] <= acc_q[ch] + sum / DIV;
                    rem_q[ch] <= sum % DIV;
                end
            end
        end
    end

    // High-resolution volume in 10 ml steps
    // Volume still counts when a temperature fails, as only flow feeds it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hr_vol_q <= '0;
        end else if (clk_en_i) begin
            if (total_reset_i) begin
                hr_vol_q <= '0;
            end else if (vol_tick_i && !fault_i.flow_fail) begin
                hr_vol_q <= hr_vol_q + ACC_W'(meas_i.vol_inc);
            end
        end
    end

    // Outputs come straight from the accumulator flip-flops
    assign heat_energy_o     = acc_q[`ERC_CH_HEAT];
    assign cooling_energy_o  = acc_q[`ERC_CH_COOL];
    assign discount_energy_o = acc_q[`ERC_CH_DISC];
    assign addition_energy_o = acc_q[`ERC_CH_ADD];
    assign inlet_temp_sum_o  = acc_q[`ERC_CH_TIN];
    assign outlet_temp_sum_o = acc_q[`ERC_CH_TOUT];
    assign hr_volume_o       = hr_vol_q;

    // Setup lock by secondary key hold on the setup end item
    // The lock is sticky: only reset_i lifts it
    // Any break in the hold restarts the count from zero
    logic [TMR_W-1:0] hold_cnt_q;
    logic             hold_cond;

    assign hold_cond = key_secondary_i && transport_state_i && at_setup_end_item_i
                       && !setup_locked_o;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hold_cnt_q     <= '0;
            setup_locked_o <= 1'b0;
            lock_pending_o <= 1'b0;
        end else if (clk_en_i) begin
            if (!hold_cond) begin
                hold_cnt_q     <= '0;
                lock_pending_o <= 1'b0;
            end else if (hold_cnt_q >= HOLD_CYCLES - TMR_W'(1)) begin
                setup_locked_o <= 1'b1;
                lock_pending_o <= 1'b0;
                hold_cnt_q     <= '0;
            end else begin
                hold_cnt_q     <= hold_cnt_q + TMR_W'(1);
                lock_pending_o <= 1'b1;
            end
        end
    end

    // Test mode entry, time-out and primary key exit
    // The time-out runs from entry; the key counter only while held
    // Release state keeps a still-shorted contact from re-entering at once
    erc_pkg::erc_mode_t mode_q;
    logic [TMR_W-1:0]   test_tmr_q;
    logic [TMR_W-1:0]   pkey_cnt_q;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mode_q      <= erc_pkg::ERC_MODE_NORMAL;
            test_tmr_q  <= '0;
            pkey_cnt_q  <= '0;
            test_mode_o <= 1'b0;
            test_exit_o <= 1'b0;
        end else if (clk_en_i) begin
            test_exit_o <= 1'b0;
            case (mode_q)
                erc_pkg::ERC_MODE_NORMAL: begin
                    if (test_contact_i) begin
                        mode_q      <= erc_pkg::ERC_MODE_TEST;
                        test_mode_o <= 1'b1;
                        test_tmr_q  <= '0;
                        pkey_cnt_q  <= '0;
                    end
                end
                erc_pkg::ERC_MODE_TEST: begin
                    test_tmr_q <= test_tmr_q + TMR_W'(1);
                    pkey_cnt_q <= key_primary_i ? pkey_cnt_q + TMR_W'(1) : '0;
                    if (test_tmr_q >= TIMEOUT_CYCLES - TMR_W'(1) ||
                        (key_primary_i && pkey_cnt_q >= HOLD_CYCLES - TMR_W'(1))) begin
                        mode_q      <= erc_pkg::ERC_MODE_RELEASE;
                        test_mode_o <= 1'b0;
                        test_exit_o <= 1'b1;
                    end
                end
                erc_pkg::ERC_MODE_RELEASE: begin
                    // Contact must open before test mode can be entered again
                    if (!test_contact_i) begin
                        mode_q <= erc_pkg::ERC_MODE_NORMAL;
                    end
                end
                default: begin
                    mode_q      <= erc_pkg::ERC_MODE_NORMAL;
                    test_mode_o <= 1'b0;
                end
            endcase
        end
    end

    // Configuration presets and reconfiguration log
    // A refused write changes nothing and only pulses the refusal flag
    // Every accepted write is logged, unused select codes included
    logic cfg_ok;

    assign cfg_ok = !setup_locked_o && (reconfig_count_o < `ERC_REFCFG_MAX);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cfg_o.outlet_reference_temp <= `ERC_OUTLET_REF_RST;
            cfg_o.tariff_limit_a        <= '0;
            cfg_o.tariff_limit_b        <= '0;
            cfg_o.tariff_limit_c        <= '0;
            cfg_o.tariff_type_code      <= `ERC_TARIFF_OFF;
            reconfig_count_o            <= '0;
            cfg_refused_o               <= 1'b0;
        end else if (clk_en_i) begin
            cfg_refused_o <= cfg_wr_i && !cfg_ok;
            if (cfg_wr_i && cfg_ok) begin
                reconfig_count_o <= reconfig_count_o + 8'h01;
                case (cfg_sel_i)
                    erc_pkg::ERC_SEL_OUTLET_REF: cfg_o.outlet_reference_temp <= cfg_data_i;
                    erc_pkg::ERC_SEL_LIMIT_A:    cfg_o.tariff_limit_a <= cfg_data_i;
                    erc_pkg::ERC_SEL_LIMIT_B:    cfg_o.tariff_limit_b <= cfg_data_i;
                    erc_pkg::ERC_SEL_LIMIT_C:    cfg_o.tariff_limit_c <= cfg_data_i;
                    erc_pkg::ERC_SEL_TARIFF:     cfg_o.tariff_type_code <= cfg_data_i[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Tariff limits only take effect with a tariff type chosen
    // Registered, so the flag lags the type code by one cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tariff_active_o <= 1'b0;
        end else if (clk_en_i) begin
            tariff_active_o <= (cfg_o.tariff_type_code != `ERC_TARIFF_OFF);
        end
    end

endmodule
`default_nettype wire

// >>> sim/erc_sensor_model.sv
// Behavioural flow sensor and temperature front end for the calculator bench
`timescale 1ns/1ns
`default_nettype none
module erc_sensor_model (
    input  wire logic               core_clk_i,
    input  wire logic               send_i,
    input  wire erc_pkg::erc_meas_t sample_i,
    output logic                    vol_tick_o,
    output erc_pkg::erc_meas_t      meas_o
);
    initial begin
        vol_tick_o = 1'b0;
        meas_o     = '0;
    end
    // One volume pulse per request; idle lines toggle so stale data never looks valid
    always @(negedge core_clk_i) begin
        vol_tick_o <= send_i;
        meas_o     <= send_i ? sample_i : ~meas_o;
    end
endmodule
`default_nettype wire

// >>> sim/erc_calc_chk.sv
// Port-level property checker for the energy register calculator
`timescale 1ns/1ns
`default_nettype none
module erc_calc_chk #(
    parameter int ACC_W = 64
) (
    input wire logic                core_clk_i,
    input wire logic                reset_i,
    input wire logic                clk_en_i,
    input wire logic                total_reset_i,
    input wire logic                vol_tick_i,
    input wire erc_pkg::erc_meas_t  meas_i,
    input wire erc_pkg::erc_fault_t fault_i,
    input wire logic                cfg_wr_i,
    input wire logic                key_secondary_i,
    input wire logic                test_contact_i,
    input wire logic [ACC_W-1:0]    heat_energy_o,
    input wire logic [ACC_W-1:0]    hr_volume_o,
    input wire erc_pkg::erc_cfg_t   cfg_o,
    input wire logic                tariff_active_o,
    input wire logic                setup_locked_o,
    input wire logic                lock_pending_o,
    input wire logic                test_mode_o,
    input wire logic                test_exit_o,
    input wire logic [7:0]          reconfig_count_o,
    input wire logic                cfg_refused_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic tick_ok;
    // An integration that the core takes
    assign tick_ok = vol_tick_i && clk_en_i && !total_reset_i;
    a_heat_zero_diff: assert property (tick_ok && meas_i.inlet_temp <= meas_i.outlet_temp
        |=> $stable(heat_energy_o)) else $error("heat grew without positive difference");
    a_volume_step: assert property (tick_ok && !fault_i.flow_fail
        |=> hr_volume_o == $past(hr_volume_o) + ACC_W'($past(meas_i.vol_inc)))
        else $error("volume step wrong");
    a_flow_fault_hold: assert property (tick_ok && fault_i.flow_fail
        |=> $stable(hr_volume_o)) else $error("volume counted during flow fault");
    a_total_clear: assert property (total_reset_i && clk_en_i
        |=> hr_volume_o == '0 && heat_energy_o == '0) else $error("total reset left values");
    a_count_step: assert property (cfg_wr_i && clk_en_i && !setup_locked_o
        && reconfig_count_o < 8'h19 |=> reconfig_count_o == $past(reconfig_count_o) + 8'h01
        && !cfg_refused_o) else $error("accepted write not logged");
    a_refuse_pulse: assert property (cfg_wr_i && clk_en_i
        && (setup_locked_o || reconfig_count_o >= 8'h19) |=> cfg_refused_o
        && $stable(reconfig_count_o) && $stable(cfg_o)) else $error("write not refused");
    a_lock_cause: assert property ($rose(setup_locked_o)
        |-> $past(lock_pending_o) && $past(key_secondary_i)) else $error("lock without hold");
    a_lock_abandon: assert property (lock_pending_o && !key_secondary_i && clk_en_i
        |=> !lock_pending_o && !setup_locked_o) else $error("lock not abandoned");
    a_test_entry: assert property ($rose(test_mode_o)
        |-> $past(test_contact_i)) else $error("test mode without contact");
    a_test_exit: assert property (test_exit_o
        |-> !test_mode_o && $past(test_mode_o)) else $error("exit pulse out of place");
    a_tariff_follow: assert property (!$past(reset_i)
        |-> tariff_active_o == ($past(cfg_o.tariff_type_code) != 8'h00))
        else $error("tariff active wrong");
    c_locked: cover property ($rose(setup_locked_o));
    c_exit: cover property (test_exit_o);
    c_refused: cover property (cfg_refused_o);
endmodule
bind erc_calc erc_calc_chk #(.ACC_W(ACC_W)) i_erc_calc_chk (
    .core_clk_i, .reset_i, .clk_en_i, .total_reset_i, .vol_tick_i, .meas_i, .fault_i,
    .cfg_wr_i, .key_secondary_i, .test_contact_i, .heat_energy_o, .hr_volume_o, .cfg_o,
    .tariff_active_o, .setup_locked_o, .lock_pending_o, .test_mode_o, .test_exit_o,
    .reconfig_count_o, .cfg_refused_o);
`default_nettype wire

// >>> sim/test_energy_register_calculator.sv
// Self-checking bench for the energy register calculator
`timescale 1ns/1ns
`default_nettype none
module test_energy_register_calculator;
    localparam int HOLD = 20;
    localparam int TMO  = 50;
    logic                  core_clk_i = 1'b0, reset_i = 1'b1, total_reset_i = 1'b0;
    logic                  send = 1'b0, flow_in_outlet_i = 1'b0, cfg_wr_i = 1'b0, clk_en_i = 1'b1;
    logic                  transport_state_i = 1'b0, at_setup_end_item_i = 1'b0;
    logic                  key_primary_i = 1'b0, key_secondary_i = 1'b0, test_contact_i = 1'b0;
    logic [15:0]           cfg_data_i = 16'h0000;
    erc_pkg::erc_cfg_sel_t cfg_sel_i = erc_pkg::ERC_SEL_OUTLET_REF;
    erc_pkg::erc_meas_t    samp = '0, meas;
    erc_pkg::erc_fault_t   fault_i = '0;
    erc_pkg::erc_cfg_t     cfg_o, ec;
    wire logic [6:0][63:0] acc_o;
    logic                  vol_tick, tariff_active_o, setup_locked_o, lock_pending_o;
    logic                  test_mode_o, test_exit_o, cfg_refused_o, lk;
    logic [7:0]            reconfig_count_o;
    longint                ex [7];
    longint                dv [7] = '{10000000, 10000000, 10000000, 10000000, 10000, 10000, 1};
    int                    ncfg, bad_count, cmp_count;
    logic [31:0]           seed = 32'h0000002b;
    erc_sensor_model i_erc_sensor_model (.core_clk_i, .send_i(send), .sample_i(samp),
        .vol_tick_o(vol_tick), .meas_o(meas));
    erc_calc #(.HOLD_CYCLES(48'(HOLD)), .TIMEOUT_CYCLES(48'(TMO))) i_erc_calc (
        .core_clk_i, .reset_i, .clk_en_i, .total_reset_i, .vol_tick_i(vol_tick),
        .meas_i(meas), .fault_i, .flow_in_outlet_i, .cfg_wr_i, .cfg_sel_i, .cfg_data_i,
        .transport_state_i, .at_setup_end_item_i, .key_primary_i, .key_secondary_i,
        .test_contact_i, .heat_energy_o(acc_o[0]), .cooling_energy_o(acc_o[1]),
        .discount_energy_o(acc_o[2]), .addition_energy_o(acc_o[3]), .inlet_temp_sum_o(acc_o[4]),
        .outlet_temp_sum_o(acc_o[5]), .hr_volume_o(acc_o[6]), .cfg_o, .tariff_active_o,
        .setup_locked_o, .lock_pending_o, .test_mode_o, .test_exit_o, .reconfig_count_o,
        .cfg_refused_o);
    // Clock at 50 MHz
    always #10 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    // Reference model reset; a full reset also restores presets, log and lock
    task automatic clr(input logic all);
        foreach (ex[i]) ex[i] = 0;
        if (all) begin
            ec = '0;
            ec.outlet_reference_temp = 16'h1388;
            ncfg = 0;
            lk = 1'b0;
        end
    endtask
    task automatic check_all();
        for (int i = 0; i < 7; i++) chk(acc_o[i], 80'(ex[i] / dv[i]), "accumulator");
    endtask
    // One random integration through the sensor model, mirrored in the reference sums
    task automatic integ();
        logic [31:0]         r;
        erc_pkg::erc_meas_t  s;
        erc_pkg::erc_fault_t f;
        longint              ti, to, rf, k, v, d;
        r = rnd();
        s.vol_inc = r[7:0];
        s.inlet_temp = 16'(r[21:8]) - 16'sd1000;
        s.outlet_temp = (r[24:22] == 3'h0) ? s.inlet_temp : 16'(rnd() % 16383) - 16'sd1000;
        s.coef_inlet = 16'(rnd() % 4096) + 16'd3000;
        s.coef_outlet = 16'(rnd() % 4096) + 16'd3000;
        f = (r[27:25] == 3'h0) ? erc_pkg::erc_fault_t'(r[30:28]) : '0;
        ti = s.inlet_temp;
        to = s.outlet_temp;
        rf = ec.outlet_reference_temp;
        k = r[31] ? s.coef_outlet : s.coef_inlet;
        v = s.vol_inc;
        d = ti - to;
        if (f == '0) begin
            if (d > 0) begin
                ex[0] += v * d * k;
                if (rf > to) ex[2] += v * (rf - to) * k;
                if (to > rf) ex[3] += v * (to - rf) * k;
            end else ex[1] -= v * d * k;
        end
        if (!f.inlet_fail && !f.flow_fail && ti > 0) ex[4] += v * ti;
        if (!f.outlet_fail && !f.flow_fail && to > 0) ex[5] += v * to;
        if (!f.flow_fail) ex[6] += v;
        @(negedge core_clk_i);
        samp <= s;
        fault_i <= f;
        flow_in_outlet_i <= r[31];
        send <= 1'b1;
        @(negedge core_clk_i);
        send <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        check_all();
    endtask
    // One preset write with its expected acceptance or refusal
    task automatic cfg(input logic [2:0] sel, input logic [15:0] d);
        logic rf;
        rf = lk || ncfg >= 25;
        @(negedge core_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_sel_i <= erc_pkg::erc_cfg_sel_t'(sel);
        cfg_data_i <= d;
        @(negedge core_clk_i);
        cfg_wr_i <= 1'b0;
        chk(80'(cfg_refused_o), 80'(rf), "refused");
        if (!rf) begin
            ncfg++;
            case (sel)
                3'h0: ec.outlet_reference_temp = d;
                3'h1: ec.tariff_limit_a = d;
                3'h2: ec.tariff_limit_b = d;
                3'h3: ec.tariff_limit_c = d;
                default: ec.tariff_type_code = d[7:0];
            endcase
        end
        @(negedge core_clk_i);
        chk(80'(cfg_o), 80'(ec), "presets");
        chk(80'(reconfig_count_o), 80'(ncfg), "log");
        chk(80'(tariff_active_o), 80'(ec.tariff_type_code != 8'h00), "tariff");
    endtask
    // Hold the secondary key on the setup-end item in transport state, then let go
    task automatic hold_sec(input int n, input logic exp_lk);
        @(negedge core_clk_i);
        {transport_state_i, at_setup_end_item_i, key_secondary_i} <= 3'b111;
        repeat (n) @(negedge core_clk_i);
        chk(80'({lock_pending_o, setup_locked_o}), 80'({!exp_lk, exp_lk}), "hold");
        key_secondary_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk(80'({lock_pending_o, setup_locked_o}), 80'({1'b0, exp_lk}), "release");
        lk = exp_lk;
    endtask
    task automatic enter_test();
        @(negedge core_clk_i);
        test_contact_i <= 1'b1;
        @(negedge core_clk_i);
        test_contact_i <= 1'b0;
        chk(80'(test_mode_o), 80'(1), "test entry");
    endtask
    task automatic await_exit(input int lo, input int hi);
        int n = 0;
        while (test_exit_o !== 1'b1 && n < hi + 4) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(80'(n >= lo && n <= hi), 80'(1), "exit time");
        chk(80'(test_mode_o), 80'(0), "left test");
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        clr(1'b1);
        repeat (20) @(negedge core_clk_i);
        reset_i <= 1'b0;
        @(negedge core_clk_i);
        check_all();
        chk(80'(cfg_o), 80'(ec), "reset presets");
        repeat (60) integ();
        for (int i = 0; i < 5; i++) cfg(3'(i), 16'(rnd()));
        cfg(3'h4, 16'h0000);
        repeat (20) integ();
        @(negedge core_clk_i);
        total_reset_i <= 1'b1;
        @(negedge core_clk_i);
        total_reset_i <= 1'b0;
        clr(1'b0);
        @(negedge core_clk_i);
        check_all();
        chk(80'(cfg_o), 80'(ec), "presets kept");
        // A write while the clock enable is low must be ignored and not logged
        @(negedge core_clk_i);
        {clk_en_i, cfg_wr_i} <= 2'b01;
        cfg_data_i <= 16'h5a5a;
        @(negedge core_clk_i);
        {clk_en_i, cfg_wr_i} <= 2'b10;
        @(negedge core_clk_i);
        chk(80'({cfg_o, reconfig_count_o}), 80'({ec, 8'(ncfg)}), "frozen");
        hold_sec(10, 1'b0);
        hold_sec(HOLD + 3, 1'b1);
        cfg(3'h1, 16'h1234);
        reset_i <= 1'b1;
        repeat (2) @(negedge core_clk_i);
        reset_i <= 1'b0;
        clr(1'b1);
        repeat (26) cfg(3'(rnd() % 5), 16'(rnd()));
        enter_test();
        key_primary_i <= 1'b1;
        await_exit(HOLD - 2, HOLD + 2);
        key_primary_i <= 1'b0;
        enter_test();
        await_exit(TMO - 2, TMO + 2);
        repeat (10) integ();
        complete_run();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge core_clk_i);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
